// ===== hdl/i2cm_master_seq.sv
// I2C master receive, acknowledge, stop and repeated-start sequencer
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module i2cm_master_seq
   import i2cm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // I2C pins
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   // Completion event
   output logic             master_irq
);
   import i2cm_pkg::*;

   typedef struct packed {
      i2cm_state_e         fsm;
      logic [4:0]          seq;
      logic                ackData;
      logic [7:0]          shift;
      logic [2:0]          bitCnt;
      logic [7:0]          rxBuf;
      logic [7:0]          txBuf;
      logic                rxFull, rxOvf, wcol, irqFlag;
      logic                startDet, stopDet;
      logic [BAUD_W-1:0]   baud;
      logic                sclMeta, sclSync, sclPrev;
      logic                sdaMeta, sdaSync, sdaPrev;
      logic                sclDrive, sdaDrive;
      logic                sclLevel, sdaLevel;
      logic                irq, ack;
      logic [31:0]         datO;
   } i2cm_regs_s;

   i2cm_regs_s stateReg;
   i2cm_regs_s stateNext;
   logic       baudRestart, baudTmo;
   logic       busy, take;
   logic       ctrlWr, statWr, txWr, rxRd;
   logic       rxDone;
   logic       stopEdge, startEdge;
   logic [31:0] rdData;

   i2cm_baud_gen #(
      .WIDTH       (BAUD_W)
   ) baudGen (
      .clk         (clk),
      .reset_n     (reset_n),
      .ce          (ce),
      .reloadValue (stateReg.baud),
      .restart     (baudRestart),
      .timeout     (baudTmo)
   );

   assign busy      = |stateReg.seq;
   assign take      = wb_cyc_i && wb_stb_i && !stateReg.ack;
   assign ctrlWr    = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL;
   assign statWr    = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_STATUS;
   assign txWr      = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_TXBUF;
   assign rxRd      = take && !wb_we_i && wb_adr_i == ADDR_RXBUF;
   assign rxDone    = stateReg.fsm == I2CM_RX_HIGH && baudTmo
                      && stateReg.bitCnt == LAST_BIT;
   // Bus conditions seen by the slave-side monitor
   assign stopEdge  = stateReg.sclSync && stateReg.sclPrev
                      && stateReg.sdaSync && !stateReg.sdaPrev;
   assign startEdge = stateReg.sclSync && stateReg.sclPrev
                      && !stateReg.sdaSync && stateReg.sdaPrev;

   always_comb begin
      rdData = '0;
      unique case (wb_adr_i)
         ADDR_CTRL: begin
            rdData[4:0]              = stateReg.seq;
            rdData[CTRL_ACKDATA_BIT] = stateReg.ackData;
         end
         ADDR_STATUS: begin
            rdData[STAT_RXFULL_BIT] = stateReg.rxFull;
            rdData[STAT_START_BIT]  = stateReg.startDet;
            rdData[STAT_STOP_BIT]   = stateReg.stopDet;
            rdData[STAT_OVF_BIT]    = stateReg.rxOvf;
            rdData[STAT_WCOL_BIT]   = stateReg.wcol;
            rdData[STAT_IRQ_BIT]    = stateReg.irqFlag;
            rdData[STAT_BUSY_BIT]   = busy;
         end
         ADDR_RXBUF: rdData[7:0] = stateReg.rxBuf;
         ADDR_TXBUF: rdData[7:0] = stateReg.txBuf;
         ADDR_BAUD:  rdData[BAUD_W-1:0] = stateReg.baud;
         default:    rdData = '0;
      endcase
   end

   always_comb begin
      stateNext   = stateReg;
      baudRestart = 1'b0;
      stateNext.irq = 1'b0;
      // Two-stage synchronisers on the open-drain lines
      stateNext.sclMeta = sclIn;
      stateNext.sclSync = stateReg.sclMeta;
      stateNext.sclPrev = stateReg.sclSync;
      stateNext.sdaMeta = sdaIn;
      stateNext.sdaSync = stateReg.sdaMeta;
      stateNext.sdaPrev = stateReg.sdaSync;

      // Bus access: answer one cycle after the request, unmapped reads zero
      stateNext.ack = take;
      if (take) begin
         stateNext.datO = rdData;
      end
      if (rxRd) begin
         stateNext.rxFull = 1'b0;
      end
      if (ctrlWr) begin
         stateNext.ackData = wb_dat_i[CTRL_ACKDATA_BIT];
         if (!busy) begin
            // Start generation is not in this block, so bit 0 stays clear
            stateNext.seq = {wb_dat_i[CTRL_SEQ_BITS-1:1], 1'b0};
         end
      end
      if (statWr) begin
         // Sticky flags clear on a written zero
         if (!wb_dat_i[STAT_OVF_BIT])  stateNext.rxOvf   = 1'b0;
         if (!wb_dat_i[STAT_WCOL_BIT]) stateNext.wcol    = 1'b0;
         if (!wb_dat_i[STAT_IRQ_BIT])  stateNext.irqFlag = 1'b0;
      end
      if (take && wb_we_i && wb_adr_i == ADDR_BAUD) begin
         if (wb_sel_i[0]) stateNext.baud[7:0]  = wb_dat_i[7:0];
         if (wb_sel_i[1]) stateNext.baud[15:8] = wb_dat_i[15:8];
      end
      if (txWr) begin
         if (busy) begin
            stateNext.wcol = 1'b1;
         end else begin
            stateNext.txBuf = wb_dat_i[7:0];
         end
      end

      // Slave-side bus monitor
      if (stopEdge) begin
         stateNext.stopDet  = 1'b1;
         stateNext.startDet = 1'b0;
      end else if (startEdge) begin
         stateNext.startDet = 1'b1;
         stateNext.stopDet  = 1'b0;
      end

      unique case (stateReg.fsm)
         I2CM_IDLE: begin
            if (stateReg.seq[CTRL_RESTART_BIT]) begin
               stateNext.sclDrive = 1'b1;
               stateNext.sdaDrive = 1'b0;
               stateNext.fsm      = I2CM_RS_PULL;
            end else if (stateReg.seq[CTRL_STOP_BIT]) begin
               stateNext.sdaDrive = 1'b1;
               baudRestart        = 1'b1;
               stateNext.fsm      = I2CM_STOP_A;
            end else if (stateReg.seq[CTRL_RX_BIT]) begin
               stateNext.sclDrive = 1'b1;
               stateNext.sdaDrive = 1'b0;
               stateNext.bitCnt   = '0;
               baudRestart        = 1'b1;
               stateNext.fsm      = I2CM_RX_LOW;
            end else if (stateReg.seq[CTRL_ACK_BIT]) begin
               stateNext.sclDrive = 1'b1;
               stateNext.fsm      = I2CM_ACK_WAIT;
            end
         end
         I2CM_RX_LOW: if (baudTmo) begin
            stateNext.sclDrive = 1'b0;
            stateNext.fsm      = I2CM_RX_WAIT;
         end
         // A stretching slave holds the line; count only after release
         I2CM_RX_WAIT: if (stateReg.sclSync) begin
            baudRestart   = 1'b1;
            stateNext.fsm = I2CM_RX_HIGH;
         end
         I2CM_RX_HIGH: if (baudTmo) begin
            stateNext.shift    = {stateReg.shift[6:0], stateReg.sdaSync};
            stateNext.sclDrive = 1'b1;
            stateNext.bitCnt   = stateReg.bitCnt + 1'b1;
            stateNext.fsm      = I2CM_RX_LOW;
            if (rxDone) begin
               stateNext.seq[CTRL_RX_BIT] = 1'b0;
               stateNext.irq = 1'b1;
               stateNext.fsm = I2CM_IDLE;
               // A read in this same cycle frees the buffer first
               if (stateReg.rxFull && !rxRd) begin
                  stateNext.rxOvf = 1'b1;
               end else begin
                  stateNext.rxBuf  = {stateReg.shift[6:0], stateReg.sdaSync};
                  stateNext.rxFull = 1'b1;
               end
            end
         end
         I2CM_ACK_WAIT: if (!stateReg.sclSync) begin
            stateNext.sdaDrive = !stateReg.ackData;
            baudRestart        = 1'b1;
            stateNext.fsm      = I2CM_ACK_LOW;
         end
         I2CM_ACK_LOW: if (baudTmo) begin
            stateNext.sclDrive = 1'b0;
            stateNext.fsm      = I2CM_ACK_HIGH;
         end
         I2CM_ACK_HIGH: if (baudTmo) begin
            stateNext.sclDrive          = 1'b1;
            stateNext.sdaDrive          = 1'b0;
            stateNext.seq[CTRL_ACK_BIT] = 1'b0;
            stateNext.irq               = 1'b1;
            stateNext.fsm               = I2CM_IDLE;
         end
         I2CM_STOP_A: if (baudTmo) begin
            stateNext.sclDrive = 1'b0;
            stateNext.fsm      = I2CM_STOP_B;
         end
         I2CM_STOP_B: if (baudTmo) begin
            stateNext.sdaDrive = 1'b0;
            stateNext.fsm      = I2CM_STOP_C;
         end
         I2CM_STOP_C: if (baudTmo) begin
            stateNext.seq[CTRL_STOP_BIT] = 1'b0;
            stateNext.irq                = 1'b1;
            stateNext.fsm                = I2CM_IDLE;
         end
         I2CM_RS_PULL: if (!stateReg.sclSync) begin
            baudRestart   = 1'b1;
            stateNext.fsm = I2CM_RS_SDA;
         end
         // Held here while a slave still pulls SDA low
         I2CM_RS_SDA: if (baudTmo && stateReg.sdaSync) begin
            stateNext.sclDrive = 1'b0;
            stateNext.fsm      = I2CM_RS_WAIT;
         end
         I2CM_RS_WAIT: if (stateReg.sclSync) begin
            baudRestart   = 1'b1;
            stateNext.fsm = I2CM_RS_HOLD;
         end
         I2CM_RS_HOLD: if (!stateReg.sclSync || !stateReg.sdaSync) begin
            baudRestart = 1'b1;
         end else if (baudTmo) begin
            stateNext.sdaDrive = 1'b1;
            stateNext.fsm      = I2CM_RS_LOW;
         end
         I2CM_RS_LOW: if (baudTmo) begin
            stateNext.sclDrive               = 1'b1;
            stateNext.seq[CTRL_RESTART_BIT]  = 1'b0;
            stateNext.irq                    = 1'b1;
            stateNext.fsm                    = I2CM_IDLE;
         end
         default: stateNext.fsm = I2CM_IDLE;
      endcase
      if (stateNext.irq) begin
         stateNext.irqFlag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stateReg          <= '0;
         stateReg.fsm      <= I2CM_IDLE;
         stateReg.baud     <= BAUD_RESET;
         stateReg.rxBuf    <= BYTE_RESET;
         stateReg.txBuf    <= BYTE_RESET;
         stateReg.sclMeta  <= 1'b1;
         stateReg.sclSync  <= 1'b1;
         stateReg.sclPrev  <= 1'b1;
         stateReg.sdaMeta  <= 1'b1;
         stateReg.sdaSync  <= 1'b1;
         stateReg.sdaPrev  <= 1'b1;
      end else if (ce) begin
         stateReg <= stateNext;
      end
   end

   assign wb_dat_o   = stateReg.datO;
   assign wb_ack_o   = stateReg.ack;
   assign sclOut     = stateReg.sclLevel;
   assign sclOe      = stateReg.sclDrive;
   assign sdaOut     = stateReg.sdaLevel;
   assign sdaOe      = stateReg.sdaDrive;
   assign master_irq = stateReg.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !ce);

   sequence seqDoneIrq;
      ##1 (master_irq && stateReg.fsm == I2CM_IDLE);
   endsequence

   sequence seqRxStart;
      stateReg.fsm == I2CM_IDLE && stateReg.seq == 5'h08;
   endsequence

   chk_rx_start_scl: assert property (seqRxStart |=> sclOe && stateReg.fsm == I2CM_RX_LOW)
      else $error("receive did not start with SCL low");
   chk_rx_byte_load: assert property (rxDone && !stateReg.rxFull |-> seqDoneIrq
      ##0 (stateReg.rxFull && !stateReg.seq[CTRL_RX_BIT]))
      else $error("completed byte not loaded");
   chk_rx_read_clr: assert property (rxRd && !rxDone |=> !stateReg.rxFull)
      else $error("buffer read left full flag set");
   chk_rx_ovf_keep: assert property (rxDone && stateReg.rxFull && !rxRd
      |=> stateReg.rxOvf && stateReg.rxBuf == $past(stateReg.rxBuf))
      else $error("overflow not flagged or buffer overwritten");
   chk_tx_collision: assert property (txWr && busy
      |=> stateReg.wcol && stateReg.txBuf == $past(stateReg.txBuf))
      else $error("transmit write during sequence not refused");
   chk_ctrl_locked: assert property (ctrlWr && busy && stateReg.fsm != I2CM_IDLE
      && !baudTmo |=> stateReg.seq == $past(stateReg.seq))
      else $error("sequence bits changed while busy");
   chk_ack_sda_level: assert property (stateReg.fsm == I2CM_ACK_WAIT && !stateReg.sclSync
      |=> sdaOe == !stateReg.ackData ##1 sdaOe == !stateReg.ackData)
      else $error("acknowledge level wrong");
   chk_ack_finish: assert property (stateReg.fsm == I2CM_ACK_HIGH && baudTmo
      |-> seqDoneIrq ##0 (sclOe && !sdaOe && !stateReg.seq[CTRL_ACK_BIT]))
      else $error("acknowledge did not finish");
   chk_stop_finish: assert property (stateReg.fsm == I2CM_STOP_C && baudTmo
      |-> seqDoneIrq ##0 (!sdaOe && !sclOe && !stateReg.seq[CTRL_STOP_BIT]))
      else $error("stop did not finish");
   chk_stop_status: assert property (stopEdge |=> stateReg.stopDet && !stateReg.startDet)
      else $error("stop not recorded");
   chk_rs_finish: assert property (stateReg.fsm == I2CM_RS_LOW && baudTmo
      |-> seqDoneIrq ##0 (sclOe && sdaOe && !stateReg.seq[CTRL_RESTART_BIT]))
      else $error("repeated start did not finish");
   chk_rx_stretch: assert property (stateReg.fsm == I2CM_RX_WAIT && !stateReg.sclSync
      |=> stateReg.fsm == I2CM_RX_WAIT && !sclOe)
      else $error("stretched clock not honoured");
endmodule
`default_nettype wire

// ===== hdl/i2cm_pkg.sv
// Constants, field layout and state encoding for the I2C master sequencer
package i2cm_pkg;

   // Wishbone byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RXBUF  = 8'h08;
   localparam logic [7:0] ADDR_TXBUF  = 8'h0C;
   localparam logic [7:0] ADDR_BAUD   = 8'h10;

   // Control register fields
   localparam int CTRL_START_BIT   = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam int CTRL_STOP_BIT    = 2;
   localparam int CTRL_RX_BIT      = 3;
   localparam int CTRL_ACK_BIT     = 4;
   localparam int CTRL_ACKDATA_BIT = 5;
   localparam int CTRL_SEQ_BITS    = 5;

   // Status register fields
   localparam int STAT_RXFULL_BIT  = 1;
   localparam int STAT_START_BIT   = 3;
   localparam int STAT_STOP_BIT    = 4;
   localparam int STAT_OVF_BIT     = 6;
   localparam int STAT_WCOL_BIT    = 7;
   localparam int STAT_IRQ_BIT     = 8;
   localparam int STAT_BUSY_BIT    = 14;

   // Baud generator
   localparam int              BAUD_W     = 16;
   localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0031;

   // Reset value and last receive bit index
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] LAST_BIT   = 3'h7;

   typedef enum logic [3:0] {
      I2CM_IDLE,
      I2CM_RX_LOW,
      I2CM_RX_WAIT,
      I2CM_RX_HIGH,
      I2CM_ACK_WAIT,
      I2CM_ACK_LOW,
      I2CM_ACK_HIGH,
      I2CM_STOP_A,
      I2CM_STOP_B,
      I2CM_STOP_C,
      I2CM_RS_PULL,
      I2CM_RS_SDA,
      I2CM_RS_WAIT,
      I2CM_RS_HOLD,
      I2CM_RS_LOW
   } i2cm_state_e;

endpackage

// ===== hdl/i2cm_baud_gen.sv
// Baud period counter with restart and one-cycle timeout pulse
`timescale 1ns/10ps
`default_nettype none
module i2cm_baud_gen #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   // Control
   input  wire logic [WIDTH-1:0] reloadValue,
   input  wire logic             restart,
   // Event
   output logic                  timeout
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             tmo;
   } i2cm_baud_s;

   i2cm_baud_s baudReg;
   i2cm_baud_s baudNext;

   always_comb begin
      baudNext     = baudReg;
      baudNext.tmo = 1'b0;
      if (restart) begin
         baudNext.count = reloadValue;
      end else if (baudReg.count == '0) begin
         baudNext.tmo   = 1'b1;
         baudNext.count = reloadValue;
      end else begin
         baudNext.count = baudReg.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         baudReg <= '0;
      end else if (ce) begin
         baudReg <= baudNext;
      end
   end

   assign timeout = baudReg.tmo;
endmodule
`default_nettype wire

// ===== testbench/i2cm_slave_model.sv
// Behavioural I2C slave that answers master reads and stretches SCL
`timescale 1ns/10ps
`default_nettype none
module i2cm_slave_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Bus wire
   input  wire logic       scl,
   output logic            sclPull,
   output logic            sdaPull,
   // Bench control
   input  wire logic       load,
   input  wire logic [7:0] loadByte,
   input  wire logic [3:0] stretch
);
   logic [7:0] shiftReg;
   logic [3:0] bitsLeft;
   logic [3:0] holdCnt;
   logic       sclPrev;
   logic       armed;

   always_ff @(posedge clk) begin
      sclPrev <= scl;
      if (!reset_n) begin
         shiftReg <= 8'h00;
         bitsLeft <= 4'h0;
         holdCnt  <= 4'h0;
      end else if (load) begin
         shiftReg <= loadByte;
         bitsLeft <= 4'h8;
      end else if (sclPrev && !scl && armed && bitsLeft != 4'h0) begin
         // Next bit only after the fall, so the master's sample stays stable
         shiftReg <= {shiftReg[6:0], 1'b1};
         bitsLeft <= bitsLeft - 4'h1;
         holdCnt  <= stretch;
      end else if (holdCnt != 4'h0) begin
         holdCnt <= holdCnt - 4'h1;
      end
      // A fall before the first rise only brings SCL down, it ends no bit
      if (!reset_n || load) begin
         armed <= 1'b0;
      end else if (!sclPrev && scl) begin
         armed <= 1'b1;
      end
   end

   // Released lines float to the pull-up level
   assign sdaPull = (bitsLeft != 4'h0) && !shiftReg[7];
   assign sclPull = (holdCnt != 4'h0);
endmodule
`default_nettype wire

// ===== testbench/i2c_master_rx_ack_stop_restart_tb.sv
// Self-checking bench for the I2C master sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin miscompares++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module i2c_master_rx_ack_stop_restart_tb;
   import i2cm_pkg::*;
   logic        clk, reset_n, ce, cyc, stb, we, ack, irq, slvLoad;
   logic [7:0]  adr, slvByte;
   logic [3:0]  sel, stretch;
   logic [31:0] datW, datR;
   logic        sclIn, sclOe, sdaIn, sdaOe, slvScl, slvSda, sdaHigh, sclOut, sdaOut;
   int          miscompares, checksDone, mFull, mOvf;
   logic [7:0]  mBuf;
   logic [7:0]  sent[$];

   // Open-drain wires with pull-ups
   assign sclIn = !((sclOe && !sclOut) | slvScl);
   assign sdaIn = !((sdaOe && !sdaOut) | slvSda);

   i2cm_master_seq i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
      .wb_dat_o(datR), .wb_ack_o(ack), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
      .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .master_irq(irq));

   i2cm_slave_model i_slave (.clk(clk), .reset_n(reset_n), .scl(sclIn), .sclPull(slvScl),
      .sdaPull(slvSda), .load(slvLoad), .loadByte(slvByte), .stretch(stretch));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic timedOut();
      miscompares++;
      $display("[FAIL] wait expected done seen timeout");
      conclude();
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= 4'hF;
      adr  <= a;
      datW <= d;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      if (n == 50) timedOut();
      r = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic chkRd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      `CHK(nm, e, r & m)
   endtask

   task automatic waitIrq();
      int n;
      sdaHigh = 1'bx;
      for (n = 0; n < 4000; n++) begin
         @(posedge clk);
         if (sclOe === 1'b0) sdaHigh = sdaOe;
         if (irq === 1'b1) break;
      end
      if (n == 4000) timedOut();
   endtask

   task automatic rxByte(input logic pokes);
      logic [7:0]  b;
      logic [31:0] r;
      b = 8'($urandom);
      sent.push_back(b);
      slvByte <= b;
      stretch <= 4'($urandom_range(9, 0));
      slvLoad <= 1'b1;
      @(posedge clk);
      slvLoad <= 1'b0;
      wb(1'b1, ADDR_CTRL, 32'h08, r);
      if (pokes) begin
         wb(1'b1, ADDR_TXBUF, 32'hA5, r);
         wb(1'b1, ADDR_CTRL, 32'h04, r);
         chkRd(ADDR_CTRL, 32'h1F, 32'h08, "ctrl busy");
         chkRd(ADDR_STATUS, 32'h4080, 32'h4080, "wcol");
         chkRd(ADDR_STATUS, 32'h80, 32'h80, "wcol kept");
         chkRd(ADDR_TXBUF, 32'hFF, 32'h5A, "tx kept");
         wb(1'b1, ADDR_STATUS, 32'h0, r);
         mOvf = 0;
      end
      waitIrq();
      if (mFull != 0) mOvf = 1;
      else mBuf = sent[0];
      mFull = 1;
      void'(sent.pop_front());
      chkRd(ADDR_CTRL, 32'h1F, 32'h0, "ctrl done");
      chkRd(ADDR_STATUS, 32'h42, 32'(mOvf) << STAT_OVF_BIT | 32'h2, "rx flags");
   endtask

   task automatic readBuf();
      chkRd(ADDR_RXBUF, 32'hFF, 32'(mBuf), "rx buffer");
      mFull = 0;
      chkRd(ADDR_STATUS, 32'h2, 32'h0, "rx full");
   endtask

   initial begin
      logic [31:0] r;
      reset_n = 1'b0;
      ce = 1'b1;
      {cyc, stb, we, slvLoad} = 4'h0;
      adr = 8'h00;
      sel = 4'hF;
      datW = 32'h0;
      slvByte = 8'h00;
      stretch = 4'h0;
      {miscompares, checksDone, mFull, mOvf} = '0;
      mBuf = 8'h00;
      void'($urandom(32'h5846));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      chkRd(ADDR_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
      chkRd(ADDR_BAUD, 32'hFFFF, 32'(BAUD_RESET), "baud reset");
      chkRd(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
      wb(1'b1, ADDR_BAUD, 32'h3, r);
      wb(1'b1, ADDR_TXBUF, 32'h5A, r);
      chkRd(ADDR_TXBUF, 32'hFF, 32'h5A, "tx store");
      $display("test reset done");
      rxByte(1'b1);
      readBuf();
      rxByte(1'b0);
      rxByte(1'b0);
      readBuf();
      rxByte(1'b0);
      readBuf();
      $display("test receive done");
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, ADDR_CTRL, 32'h10 | 32'(k) << 5, r);
         waitIrq();
         `CHK("ack level", !k[0], sdaHigh)
         chkRd(ADDR_CTRL, 32'h3F, 32'(k) << 5, "ack end");
      end
      $display("test ack done");
      wb(1'b1, ADDR_CTRL, 32'h04, r);
      waitIrq();
      chkRd(ADDR_STATUS, 32'h18, 32'h10, "stop flags");
      `CHK("stop pins", 2'b00, {sclOe, sdaOe})
      $display("test stop done");
      wb(1'b1, ADDR_CTRL, 32'h02, r);
      waitIrq();
      chkRd(ADDR_STATUS, 32'h18, 32'h08, "start flags");
      `CHK("restart pins", 2'b11, {sclOe, sdaOe})
      `CHK("drive levels", 2'b00, {sclOut, sdaOut})
      chkRd(ADDR_CTRL, 32'h1F, 32'h0, "restart end");
      $display("test restart done");
      conclude();
   end
endmodule
`default_nettype wire
